// File: design/tcs_counter.v
// One 16-bit up-counter channel with load, clear and overflow pulse.
// Assumes load and clear arrive as one-cycle strobes from the control logic.
`timescale 1ns/1ps
`default_nettype none
`include "tcs_defines.vh"
module tcs_counter #(
   parameter WIDTH = 16
) (
   input wire aclk,
   input wire aresetn,
   input wire run,
   input wire load,
   input wire [WIDTH-1:0] load_value,
   input wire clear,
   output reg [WIDTH-1:0] count,
   output reg wrap
);
   // Load wins over clear, clear over counting.
   always @(posedge aclk) begin
      if (!aresetn) begin
         count <= `TCS_CNT_RESET;
         wrap <= 1'b0;
      end else begin
         wrap <= 1'b0;
         if (load) begin
            count <= load_value;
         end else if (clear) begin
            count <= {WIDTH{1'b0}};
         end else if (run) begin
            count <= count + {{(WIDTH-1){1'b0}}, 1'b1};
            wrap <= (count == {WIDTH{1'b1}});
         end
      end
   end
endmodule // tcs_counter
`default_nettype wire

// File: design/tcs_pin_out.v
// Compare output pin level holder for one channel.
// Assumes toggle and init strobes are single cycles.
`timescale 1ns/1ps
`default_nettype none
module tcs_pin_out (
   input wire aclk,
   input wire aresetn,
   input wire run,
   input wire compare_hit,
   input wire init_write,
   input wire init_level,
   output reg level
);
   always @(posedge aclk) begin
      if (!aresetn) begin
         level <= 1'b0;
      end else if (!run && init_write) begin
         level <= init_level;
      end else if (run && compare_hit) begin
         level <= ~level;
      end
   end
endmodule // tcs_pin_out
`default_nettype wire

// File: design/tcs_top.v
// Run and synchronisation control for a two-channel 16-bit timer.
// Assumes an AXI4-Lite master that keeps one write and one read under way at a time.
//
// The register offsets and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "tcs_defines.vh"
////////////////////////////////////////////////////////////////////////////////
// How it works
// - Bit 2 runs channel 2 and bit 1 runs channel 1; a stopped counter holds.
// - Both run bits reset to 0 so both counters stand still after reset.
// - Writing pin output control of a stopped channel drives its initial level.
// - Bits 2 and 1 of the sync register make channels 2 and 1 synchronous.
// - A counter write to a synchronous channel loads all synchronous counters.
// - A synchronous channel clears with another only when its clear source says so.
// - Each counter is 16 bits, reset to zero, written only when both low byte strobes are set.
// - A wrap from all ones to zero sets the overflow flag and counting goes on.
module tcs_top #(
   parameter WIDTH = 16
) (
   input wire aclk,
   input wire aresetn,
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   input wire [1:0] compare_hit,
   output reg [1:0] timer_io_pin,
   output reg [1:0] run_state
);
   ////////////////////////////////////////////////////////////////////////////
   // Register state.
   reg [7:0] channel_run_control;
   reg [7:0] channel_sync_select;
   reg [3:0] clear_source;
   reg [1:0] overflow_flag;
   reg [1:0] pin_init;

   // Write channel holding registers.
   reg [7:0] aw_addr;
   reg aw_held;
   reg [31:0] w_data;
   reg [3:0] w_strb;
   reg w_held;
   reg aw_known;

   // Counter and pin channel wiring.
   wire [WIDTH-1:0] cnt1;
   wire [WIDTH-1:0] cnt2;
   wire [1:0] wrap;
   wire [1:0] pin_level;
   wire [1:0] run_bits;
   wire [1:0] sync_bits;

   // Decoded write strobes.
   wire do_write;
   wire byte_write;
   wire word_write;
   wire status_write;
   wire [1:0] cnt_write;
   wire [1:0] pin_write;

   // Preset and clear fan-out.
   wire [1:0] own_clear;
   wire any_sync_clear;
   wire [1:0] load;
   wire [1:0] clear;
   wire [WIDTH-1:0] load_value;
   wire [1:0] clr_ok;

   // Read channel.
   reg [31:0] next_rdata;
   reg next_rerr;

   assign run_bits = {channel_run_control[`TCS_BIT_CH2], channel_run_control[`TCS_BIT_CH1]};
   assign sync_bits = {channel_sync_select[`TCS_BIT_CH2], channel_sync_select[`TCS_BIT_CH1]};

   ////////////////////////////////////////////////////////////////////////////
   // Write channel capture: address and data in either order.
   assign do_write = aw_held && w_held && !s_axi_bvalid;
   assign word_write = do_write && (w_strb[1:0] == 2'h3);
   assign cnt_write[0] = word_write && (aw_addr == `TCS_OFF_CNT1);
   assign cnt_write[1] = word_write && (aw_addr == `TCS_OFF_CNT2);

   assign byte_write = do_write && w_strb[0];
   assign status_write = byte_write && (aw_addr == `TCS_OFF_STATUS);
   assign pin_write[0] = byte_write && (aw_addr == `TCS_OFF_PIN1);
   assign pin_write[1] = byte_write && (aw_addr == `TCS_OFF_PIN2);
   assign load_value = w_data[WIDTH-1:0];

   ////////////////////////////////////////////////////////////////////////////
   // Only the eight map words accept a write; any other address answers with an error.
   always @* begin
      case (aw_addr)
         `TCS_OFF_RUN,
         `TCS_OFF_SYNC,
         `TCS_OFF_CLRSRC,
         `TCS_OFF_STATUS,
         `TCS_OFF_CNT1,
         `TCS_OFF_CNT2,
         `TCS_OFF_PIN1,
         `TCS_OFF_PIN2: aw_known = 1'b1;
         default: aw_known = 1'b0;
      endcase
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= 8'h00;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
      end else begin
         s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
         s_axi_wready <= !w_held && !s_axi_wready && s_axi_wvalid;

         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (do_write) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Write response: one answer for each address and data pair.
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `TCS_RESP_OKAY;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= aw_known ? `TCS_RESP_OKAY : `TCS_RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Control registers.
   always @(posedge aclk) begin
      if (!aresetn) begin
         channel_run_control <= `TCS_CTRL_RESET;
         channel_sync_select <= `TCS_CTRL_RESET;
         clear_source <= 4'h0;
         pin_init <= 2'h0;
      end else if (byte_write) begin
         case (aw_addr)
            `TCS_OFF_RUN: channel_run_control <= w_data[7:0];
            `TCS_OFF_SYNC: channel_sync_select <= w_data[7:0];
            `TCS_OFF_CLRSRC: clear_source <= w_data[3:0];
            `TCS_OFF_PIN1: pin_init[0] <= w_data[0];
            `TCS_OFF_PIN2: pin_init[1] <= w_data[0];
            default: channel_run_control <= channel_run_control;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Synchronous preset and clear, one generate slice per channel.
   assign any_sync_clear = |(own_clear & sync_bits);

   genvar i;
   generate
      for (i = 0; i < 2; i = i + 1) begin : g_ch
         // Two-bit clear source field of this channel.
         wire [1:0] clr_sel;
         assign clr_sel = clear_source[2*i+1:2*i];
         assign own_clear[i] = run_bits[i] && compare_hit[i] && (clr_sel == `TCS_CLR_OWN);
         assign clr_ok[i] = sync_bits[i] && (clr_sel == `TCS_CLR_SYNC);
         // All synchronous channels load on the same edge.
         assign load[i] = cnt_write[i] || (sync_bits[i] && |(cnt_write & sync_bits));
         assign clear[i] = own_clear[i] || (clr_ok[i] && any_sync_clear);

         tcs_pin_out u_pin (
            .aclk(aclk),
            .aresetn(aresetn),
            .run(run_bits[i]),
            .compare_hit(compare_hit[i]),
            .init_write(pin_write[i]),
            .init_level(w_data[0]),
            .level(pin_level[i])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Counter channels; load wins over clear inside each counter.
   tcs_counter #(.WIDTH(WIDTH)) u_cnt1 (
      .aclk(aclk),
      .aresetn(aresetn),
      .run(run_bits[0]),
      .load(load[0]),
      .load_value(load_value),
      .clear(clear[0]),
      .count(cnt1),
      .wrap(wrap[0])
   );

   tcs_counter #(.WIDTH(WIDTH)) u_cnt2 (
      .aclk(aclk),
      .aresetn(aresetn),
      .run(run_bits[1]),
      .load(load[1]),
      .load_value(load_value),
      .clear(clear[1]),
      .count(cnt2),
      .wrap(wrap[1])
   );

   ////////////////////////////////////////////////////////////////////////////
   // Overflow flags: set wins over a software clear written as 0.
   always @(posedge aclk) begin
      if (!aresetn) begin
         overflow_flag <= 2'h0;
      end else begin
         if (status_write) begin
            overflow_flag <= (overflow_flag & w_data[1:0]) | wrap;
         end else begin
            overflow_flag <= overflow_flag | wrap;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registered pin levels and run state.
   always @(posedge aclk) begin
      if (!aresetn) begin
         timer_io_pin <= 2'h0;
         run_state <= 2'h0;
      end else begin
         timer_io_pin <= pin_level;
         run_state <= run_bits;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read channel.
   always @* begin
      next_rdata = 32'h0000_0000;
      next_rerr = 1'b0;

      case (s_axi_araddr)
         `TCS_OFF_RUN: next_rdata[7:0] = channel_run_control;
         `TCS_OFF_SYNC: next_rdata[7:0] = channel_sync_select;
         `TCS_OFF_CLRSRC: next_rdata[3:0] = clear_source;
         `TCS_OFF_STATUS: next_rdata[1:0] = overflow_flag;
         `TCS_OFF_CNT1: next_rdata[WIDTH-1:0] = cnt1;
         `TCS_OFF_CNT2: next_rdata[WIDTH-1:0] = cnt2;
         `TCS_OFF_PIN1: next_rdata[1:0] = {pin_level[0], pin_init[0]};
         `TCS_OFF_PIN2: next_rdata[1:0] = {pin_level[1], pin_init[1]};
         default: next_rerr = 1'b1;
      endcase
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `TCS_RESP_OKAY;
      end else begin
         s_axi_arready <= 1'b0;
         if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid) begin
            s_axi_arready <= 1'b1;
         end
         // Data follow the address handshake by one cycle.
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= next_rerr ? `TCS_RESP_SLVERR : `TCS_RESP_OKAY;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
endmodule // tcs_top
`default_nettype wire

// File: include/tcs_defines.vh
// Constants for the timer channel run and sync control block.
// Assumes a 32-bit AXI4-Lite register slave and a 50 MHz clock.
`ifndef TCS_DEFINES_VH
`define TCS_DEFINES_VH
`define TCS_OFF_RUN 8'h00
`define TCS_OFF_SYNC 8'h04
`define TCS_OFF_CLRSRC 8'h08
`define TCS_OFF_STATUS 8'h0c
`define TCS_OFF_CNT1 8'h10
`define TCS_OFF_CNT2 8'h14
`define TCS_OFF_PIN1 8'h18
`define TCS_OFF_PIN2 8'h1c
`define TCS_BIT_CH1 1
`define TCS_BIT_CH2 2
`define TCS_CTRL_RESET 8'h00
`define TCS_CNT_RESET 16'h0000
`define TCS_CNT_MAX 16'hffff
`define TCS_CLR_NONE 2'h0
`define TCS_CLR_OWN 2'h1
`define TCS_CLR_SYNC 2'h3
`define TCS_RESP_OKAY 2'h0
`define TCS_RESP_SLVERR 2'h2
`endif

// File: sim/tcs_checker.sv
// Port checks for the timer run and sync control top.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module tcs_checker #(
   parameter WIDTH = 16
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] run_state,
   input wire logic [1:0] timer_io_pin
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   a_reset_state: assert property (
      aresetn && !$past(aresetn) |-> run_state == 2'h0 && timer_io_pin == 2'h0)
      else $error("state not cleared by reset");
   a_run_held: assert property (
      $past(aresetn) && !s_axi_bvalid && !$past(s_axi_bvalid) |-> $stable(run_state))
      else $error("run state moved without a write");
   a_pin_frozen: assert property (
      $past(aresetn) && run_state == 2'h0 && $past(run_state) == 2'h0 && !s_axi_bvalid
      && !$past(s_axi_bvalid) |-> $stable(timer_io_pin))
      else $error("stopped pin level moved");
   a_aw_pulse: assert property (s_axi_awready |=> !s_axi_awready)
      else $error("awready longer than one cycle");
   a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read response dropped");
   a_read_answer: assert property (s_axi_arvalid && !s_axi_rvalid |-> ##[1:4] s_axi_rvalid)
      else $error("read not answered");
   a_write_answer: assert property (s_axi_awvalid && s_axi_wvalid |-> ##[1:6] s_axi_bvalid)
      else $error("write not answered");
endmodule // tcs_checker
bind tcs_top tcs_checker #(.WIDTH(WIDTH)) u_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_wvalid,
   .s_axi_awready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_rvalid,
   .s_axi_rready, .s_axi_rdata, .run_state, .timer_io_pin);
`default_nettype wire

// File: sim/tcs_top_tb_top.sv
// Self-checking bench for the timer run and sync control top.
// Assumes the register map of tcs_defines.vh and responses in request order.
`timescale 1ns/1ps
`default_nettype none
`include "tcs_defines.vh"
module tcs_top_tb_top;
   logic aclk = 1'b0, aresetn = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, timer_io_pin, run_state;
   logic [1:0] compare_hit = 2'h0;
   logic [33:0] exp_q[$];
   logic [33:0] got;
   logic [15:0] v, w;
   int n_errors = 0, total_checks = 0, k;
   localparam logic [1:0] OK = `TCS_RESP_OKAY;
   localparam logic [1:0] ERR = `TCS_RESP_SLVERR;
   always #10 aclk = ~aclk;
   tcs_top #(.WIDTH(16)) dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .compare_hit, .timer_io_pin, .run_state);
   ////////////////////////////////////////////////////////////////////////////////
   task automatic report_and_stop;
      if (n_errors == 0 && total_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      int i;
      exp_q.push_back({r, 32'h0});
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      i = 0;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         i++;
      end while (s_axi_bvalid !== 1'b1 && i < 40);
      s_axi_bready <= 1'b0;
      if (i >= 40) begin
         n_errors++;
         report_and_stop();
      end
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      int i;
      exp_q.push_back({r, d});
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      i = 0;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         i++;
      end while (s_axi_rvalid !== 1'b1 && i < 40);
      s_axi_rready <= 1'b0;
      if (i >= 40) begin
         n_errors++;
         report_and_stop();
      end
   endtask
   task automatic hit(input logic [1:0] h);
      @(posedge aclk);
      compare_hit <= h;
      @(posedge aclk);
      compare_hit <= 2'h0;
   endtask
   task automatic chk(input logic ok_bit);
      total_checks++;
      if (ok_bit !== 1'b1) begin
         n_errors++;
         $display("BAD %0t direct output check", $time);
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // Takes the oldest expected answer whenever a response is handed over.
   always @(posedge aclk) begin
      if ((s_axi_bvalid && s_axi_bready) || (s_axi_rvalid && s_axi_rready)) begin
         got = s_axi_bvalid ? {s_axi_bresp, 32'h0} : {s_axi_rresp, s_axi_rdata};
         total_checks++;
         if (exp_q.size() == 0 || got !== exp_q[0]) begin
            n_errors++;
            $display("BAD %0t got %h", $time, got);
         end
         if (exp_q.size() > 0) void'(exp_q.pop_front());
      end
   end
   initial begin
      void'($urandom(32'hd20eafb3));
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      rd(`TCS_OFF_RUN, 32'h0, OK);
      rd(`TCS_OFF_CNT1, 32'h0, OK);
      for (k = 0; k < 2; k++) begin
         rd(`TCS_OFF_RUN + 8'(4 * k), 32'h0, OK);
         wr(`TCS_OFF_RUN + 8'(4 * k), 32'h6, OK);
         rd(`TCS_OFF_RUN + 8'(4 * k), 32'h6, OK);
         wr(`TCS_OFF_RUN + 8'(4 * k), 32'h0, OK);
      end
      wr(8'h20, 32'h1, ERR);
      rd(8'h20, 32'h0, ERR);
      // Channel 2 wraps while channel 1 stays stopped.
      v = 16'($urandom);
      wr(`TCS_OFF_CNT1, {16'h0, v}, OK);
      wr(`TCS_OFF_CNT2, 32'hfff0, OK);
      wr(`TCS_OFF_RUN, 32'h4, OK);
      repeat (40) @(posedge aclk);
      wr(`TCS_OFF_RUN, 32'h0, OK);
      rd(`TCS_OFF_STATUS, 32'h2, OK);
      rd(`TCS_OFF_CNT1, {16'h0, v}, OK);
      wr(`TCS_OFF_STATUS, 32'h0, OK);
      rd(`TCS_OFF_STATUS, 32'h0, OK);
      // Synchronous preset across both channels, then a preset of channel 2 alone while only channel 1 is synchronous.
      wr(`TCS_OFF_SYNC, 32'h6, OK);
      v = 16'($urandom);
      wr(`TCS_OFF_CNT1, {16'h0, v}, OK);
      rd(`TCS_OFF_CNT2, {16'h0, v}, OK);
      wr(`TCS_OFF_SYNC, 32'h2, OK);
      w = 16'($urandom);
      wr(`TCS_OFF_CNT2, {16'h0, w}, OK);
      rd(`TCS_OFF_CNT1, {16'h0, v}, OK);
      // Own clear on channel 1 takes synchronous channel 2 along, then both count on.
      wr(`TCS_OFF_SYNC, 32'h6, OK);
      wr(`TCS_OFF_CLRSRC, 32'hd, OK);
      wr(`TCS_OFF_RUN, 32'h6, OK);
      hit(2'h1);
      chk(run_state === 2'h3);
      wr(`TCS_OFF_RUN, 32'h0, OK);
      rd(`TCS_OFF_CNT1, 32'h4, OK);
      rd(`TCS_OFF_CNT2, 32'h4, OK);
      wr(`TCS_OFF_CLRSRC, 32'h0, OK);
      wr(`TCS_OFF_SYNC, 32'h0, OK);
      // Initial level, one toggle while running, frozen once stopped.
      for (k = 0; k < 2; k++) begin
         wr(`TCS_OFF_PIN1 + 8'(4 * k), 32'h1, OK);
         rd(`TCS_OFF_PIN1 + 8'(4 * k), 32'h3, OK);
         chk(timer_io_pin[k] === 1'b1);
         wr(`TCS_OFF_RUN, 32'(2 << k), OK);
         hit(2'(1 << k));
         chk(run_state === 2'(1 << k));
         wr(`TCS_OFF_RUN, 32'h0, OK);
         hit(2'(1 << k));
         rd(`TCS_OFF_PIN1 + 8'(4 * k), 32'h1, OK);
         chk(timer_io_pin[k] === 1'b0);
         wr(`TCS_OFF_PIN1 + 8'(4 * k), 32'h0, OK);
         rd(`TCS_OFF_PIN1 + 8'(4 * k), 32'h0, OK);
      end
      repeat (3) @(posedge aclk);
      report_and_stop();
   end
endmodule // tcs_top_tb_top
`default_nettype wire
